// ==== rtl/tocc_pkg.sv ====
package tocc_pkg;

    localparam int TOCC_W = 16;
    localparam int TOCC_NCH = 3;
    localparam int TOCC_NPRE = 5;

    // prescale divide ratios for clock select 1..5
    localparam logic [10:0] TOCC_DIV_1 = 11'h001;
    localparam logic [10:0] TOCC_DIV_2 = 11'h008;
    localparam logic [10:0] TOCC_DIV_3 = 11'h040;
    localparam logic [10:0] TOCC_DIV_4 = 11'h100;
    localparam logic [10:0] TOCC_DIV_5 = 11'h400;

    localparam logic [3:0] TOCC_MODE_NORMAL = 4'h0;
    localparam logic [3:0] TOCC_MODE_CTC_A = 4'h4;
    localparam logic [3:0] TOCC_MODE_CTC_CAP = 4'hC;

    localparam logic [1:0] TOCC_ACT_NONE = 2'h0;
    localparam logic [1:0] TOCC_ACT_TOGGLE = 2'h1;
    localparam logic [1:0] TOCC_ACT_CLEAR = 2'h2;
    localparam logic [1:0] TOCC_ACT_SET = 2'h3;

    localparam logic [15:0] TOCC_MAX = 16'hFFFF;
    localparam logic [15:0] TOCC_BOTTOM = 16'h0000;
    localparam logic [15:0] TOCC_CNT_RST = 16'h0000;
    localparam logic [15:0] TOCC_CMP_RST = 16'h0000;
    localparam logic [7:0] TOCC_TEMP_RST = 8'h00;
    localparam logic [10:0] TOCC_PRE_RST = 11'h000;

    typedef enum logic [1:0] {
        TOCC_CNT_NORMAL,
        TOCC_CNT_CTC,
        TOCC_CNT_PWM
    } tocc_cnt_kind_t;

    function automatic tocc_cnt_kind_t tocc_kind(input logic [3:0] mode);
        if (mode == TOCC_MODE_NORMAL)
            return TOCC_CNT_NORMAL;
        else if (mode == TOCC_MODE_CTC_A || mode == TOCC_MODE_CTC_CAP)
            return TOCC_CNT_CTC;
        else
            return TOCC_CNT_PWM;
    endfunction : tocc_kind

endpackage : tocc_pkg

// ==== rtl/tocc_tick_if.sv ====
`timescale 1ns/1ns
interface tocc_tick_if;
    logic tick;
    logic [2:0] clk_sel;

    modport src (input clk_sel, output tick);
    modport dst (output clk_sel, input tick);
endinterface : tocc_tick_if

// ==== rtl/tocc_prescale.sv ====
`timescale 1ns/1ns
module tocc_prescale
(
    // clock and reset
    input wire logic core_clk,
    input wire logic nrst,
    // tick link
    tocc_tick_if.src tk
);
    import tocc_pkg::*;

    logic [10:0] pre_r;
    logic [10:0] div;
    logic tick_r;

    always_comb
    begin
        case (tk.clk_sel)
            3'h1: div = TOCC_DIV_1;
            3'h2: div = TOCC_DIV_2;
            3'h3: div = TOCC_DIV_3;
            3'h4: div = TOCC_DIV_4;
            3'h5: div = TOCC_DIV_5;
            default: div = TOCC_PRE_RST;
        endcase
    end

    always_ff @(posedge core_clk or negedge nrst)
    begin
        if (!nrst)
            pre_r <= TOCC_PRE_RST;
        else if (div == TOCC_PRE_RST || pre_r == div - 11'h001)
            pre_r <= TOCC_PRE_RST;
        else
            pre_r <= pre_r + 11'h001;
    end

    // stopped when select is zero or unsupported
    always_ff @(posedge core_clk or negedge nrst)
    begin
        if (!nrst)
            tick_r <= 1'b0;
        else
            tick_r <= (div != TOCC_PRE_RST) && (pre_r == div - 11'h001);
    end

    assign tk.tick = tick_r;
endmodule : tocc_prescale

// ==== rtl/tocc_core.sv ====
`timescale 1ns/1ns
// Operation
// RL1 - counter compared each cycle; match sets flag on next timer tick
// RL2 - enabled set flag raises interrupt; cleared by acknowledge or write-one
// RL3 - channel A compare can define the counter top value
// RL4 - double buffering in pulse-width modes, direct writes in normal/clear modes
// RL5 - buffered value loads at top or bottom only
// RL6 - cpu writes reach buffer when buffered, else active register
// RL7 - compare changes only by cpu writes; high read returns register
// RL8 - high byte held first; low write updates all 16 bits at once
// RL9 - force strobe acts like a match on the latch only
// RL10 - counter write blocks matches in the next timer cycle
// RL11 - software avoids writing top into counter in variable-top modes
// RL12 - output latch keeps value across mode changes
// RL13 - action bits unbuffered, used from the next match
// RL14 - reset clears the output latch
// RL15 - nonzero action overrides port value; direction stays from port bit
// RL16 - action zero leaves latch unchanged on matches
// RL17 - normal mode counts up, wraps, overflow flag set at zero
// RL18 - overflow flag set by hardware, cleared by ack or software
// RL19 - clear mode resets counter after match on A or capture value
// RL20 - clear mode top unbuffered; missed top runs through wrap
// RL21 - toggle action in clear mode halves the match frequency
// RL22 - clear mode overflow flag set on max to zero
// RL23 - counter write beats clear or count in same cycle
// RL24 - clock select zero stops counting, counter still accessible
// RL25 - hardware flag set wins over software clear
module tocc_core
(
    // clock and reset
    input wire logic core_clk,
    input wire logic nrst,
    // configuration
    input wire logic [3:0] waveform_mode_select,
    input wire logic [2:0] clock_source_select,
    input wire logic [5:0] compare_output_action,
    input wire logic [2:0] compare_irq_enable,
    input wire logic overflow_irq_enable,
    // byte access strobes, channel one-hot
    input wire logic [7:0] cpu_wdata,
    input wire logic [2:0] compare_value_high_wr,
    input wire logic [2:0] compare_value_low_wr,
    input wire logic [2:0] force_compare_strobe,
    input wire logic timer_count_high_wr,
    input wire logic timer_count_low_wr,
    input wire logic [15:0] capture_value,
    // flag clears and interrupt acknowledges
    input wire logic [2:0] compare_flag_clr,
    input wire logic [2:0] compare_irq_ack,
    input wire logic overflow_flag_clr,
    input wire logic overflow_irq_ack,
    // port pins
    input wire logic [2:0] port_value,
    input wire logic [2:0] output_pin_direction,
    // readback
    output logic [15:0] timer_count,
    output logic [47:0] compare_value,
    output logic [2:0] compare_match_flag,
    output logic overflow_flag,
    output logic capture_flag,
    output logic [2:0] compare_irq,
    output logic overflow_irq,
    output logic [2:0] compare_output_latch,
    // pins: oe low drives
    output logic [2:0] pin_out,
    output logic [2:0] pin_oe_n
);
    import tocc_pkg::*;

    tocc_tick_if tk();
    assign tk.clk_sel = clock_source_select;

    tocc_prescale u_pre
    (
        .core_clk(core_clk),
        .nrst(nrst),
        .tk(tk)
    );

    logic [15:0] cnt_r;
    logic [15:0] ocr_r [TOCC_NCH];
    logic [15:0] buf_r [TOCC_NCH];
    logic [7:0] temp_r;
    logic [2:0] flag_r;
    logic tov_r;
    logic icf_r;
    logic [2:0] latch_r;
    logic [2:0] match_pend_r;
    logic blk_r;
    logic [2:0] irq_r;
    logic tovirq_r;
    logic [2:0] pin_r;
    logic [2:0] oen_r;
    logic [15:0] cnt_nxt;
    logic [2:0] match;
    logic [2:0] hit;
    logic top_hit;
    logic cap_hit;
    logic cnt_wr;
    tocc_cnt_kind_t kind;

    logic tick_ok;
    logic buf_load;
    logic [15:0] wr_word;
    logic [2:0] flag_clr;
    logic tov_clr;
    logic [2:0] force_ok;

    // joins holding byte and written low byte
    function automatic logic [15:0] join16(input logic [7:0] hi,
        input logic [7:0] lo);
        return {hi, lo};
    endfunction : join16

    assign kind = tocc_kind(waveform_mode_select);
    assign cnt_wr = timer_count_low_wr;
    // tick that may act on matches
    assign tick_ok = tk.tick && !blk_r && !cnt_wr; // RL10
    // low byte write joins the holding byte
    assign wr_word = join16(temp_r, cpu_wdata); // RL8
    // software clears and interrupt acknowledges
    assign flag_clr = compare_flag_clr | compare_irq_ack; // RL2
    assign tov_clr = overflow_flag_clr || overflow_irq_ack; // RL18
    // force strobe honoured outside buffered modes
    assign force_ok = (kind != TOCC_CNT_PWM)
        ? force_compare_strobe : 3'h0; // RL9

    // buffered modes reload only at top or bottom
    assign buf_load = (kind == TOCC_CNT_PWM) && tk.tick
        && (cnt_r == TOCC_MAX || cnt_r == TOCC_BOTTOM); // RL5

    function automatic logic apply_act(input logic cur, input logic [1:0] act);
        case (act)
            TOCC_ACT_TOGGLE: return ~cur;
            TOCC_ACT_CLEAR: return 1'b0;
            TOCC_ACT_SET: return 1'b1;
            default: return cur; // RL16
        endcase
    endfunction : apply_act

    // comparators, blocked just after counter write
    always_comb
    begin
        for (int i = 0; i < TOCC_NCH; i++)
            match[i] = (cnt_r == ocr_r[i]); // RL1
        cap_hit = (cnt_r == capture_value);
    end

    assign top_hit = (waveform_mode_select == TOCC_MODE_CTC_A)
        ? match[0] : cap_hit; // RL3 RL19

    // match is acted on at the next timer tick
    always_ff @(posedge core_clk or negedge nrst)
    begin
        if (!nrst)
            match_pend_r <= 3'h0;
        else if (tk.tick)
            match_pend_r <= 3'h0;
        else if (cnt_wr)
            match_pend_r <= 3'h0;
        else
            match_pend_r <= match_pend_r | match;
    end

    // write blocks matches for the following timer cycle
    always_ff @(posedge core_clk or negedge nrst)
    begin
        if (!nrst)
            blk_r <= 1'b0;
        else if (cnt_wr)
            blk_r <= 1'b1; // RL10
        else if (tk.tick)
            blk_r <= 1'b0;
    end

    assign hit = tick_ok
        ? (match_pend_r | match) : 3'h0; // RL10

    // counter
    always_comb
    begin
        cnt_nxt = cnt_r;
        if (cnt_wr)
            cnt_nxt = wr_word; // RL8 RL23
        else if (tk.tick) // RL24
        begin
            if (kind == TOCC_CNT_CTC && !blk_r && top_hit)
                cnt_nxt = TOCC_BOTTOM; // RL19
            else
                cnt_nxt = cnt_r + 16'h0001; // RL17 RL20
        end
    end

    always_ff @(posedge core_clk or negedge nrst)
    begin
        if (!nrst)
            cnt_r <= TOCC_CNT_RST;
        else
            cnt_r <= cnt_nxt;
    end

    // shared high-byte holding register
    always_ff @(posedge core_clk or negedge nrst)
    begin
        if (!nrst)
            temp_r <= TOCC_TEMP_RST;
        else if (|compare_value_high_wr || timer_count_high_wr)
            temp_r <= cpu_wdata; // RL8
    end

    // compare buffer, written only in buffered modes
    always_ff @(posedge core_clk or negedge nrst)
    begin
        if (!nrst)
        begin
            for (int i = 0; i < TOCC_NCH; i++)
                buf_r[i] <= TOCC_CMP_RST;
        end
        else
        begin
            for (int i = 0; i < TOCC_NCH; i++)
            begin
                if (compare_value_low_wr[i] && kind == TOCC_CNT_PWM)
                    buf_r[i] <= wr_word; // RL4 RL6 RL8
            end
        end
    end

    // active compare: direct write or reload from buffer
    always_ff @(posedge core_clk or negedge nrst)
    begin
        if (!nrst)
        begin
            for (int i = 0; i < TOCC_NCH; i++)
                ocr_r[i] <= TOCC_CMP_RST;
        end
        else
        begin
            for (int i = 0; i < TOCC_NCH; i++)
            begin
                if (compare_value_low_wr[i] && kind != TOCC_CNT_PWM)
                    ocr_r[i] <= wr_word; // RL4 RL6 RL7
                else if (buf_load)
                    ocr_r[i] <= buf_r[i]; // RL5
            end
        end
    end

    // compare flags: set beats clear
    always_ff @(posedge core_clk or negedge nrst)
    begin
        if (!nrst)
            flag_r <= 3'h0;
        else
            flag_r <= (flag_r & ~flag_clr)
                | hit; // RL1 RL2 RL25
    end

    // capture flag marks top in capture clear mode
    always_ff @(posedge core_clk or negedge nrst)
    begin
        if (!nrst)
            icf_r <= 1'b0;
        else if (tick_ok && cap_hit
                 && waveform_mode_select == TOCC_MODE_CTC_CAP)
            icf_r <= 1'b1; // RL19
    end

    // overflow when the counter wraps max to zero
    always_ff @(posedge core_clk or negedge nrst)
    begin
        if (!nrst)
            tov_r <= 1'b0;
        else if (tk.tick && !cnt_wr && cnt_r == TOCC_MAX)
            tov_r <= 1'b1; // RL17 RL22 RL25
        else if (tov_clr)
            tov_r <= 1'b0; // RL18
    end

    // output latches
    always_ff @(posedge core_clk or negedge nrst)
    begin
        if (!nrst)
            latch_r <= 3'h0; // RL14
        else
        begin
            for (int i = 0; i < TOCC_NCH; i++)
            begin
                if (hit[i] || force_ok[i]) // RL9
                    latch_r[i] <= apply_act(latch_r[i],
                        compare_output_action[2*i +: 2]); // RL13 RL21
            end
        end
    end // RL12: no mode term above

    // compare interrupt follows flag and enable
    always_ff @(posedge core_clk or negedge nrst)
    begin
        if (!nrst)
            irq_r <= 3'h0;
        else
            irq_r <= flag_r & compare_irq_enable; // RL2
    end

    // overflow interrupt
    always_ff @(posedge core_clk or negedge nrst)
    begin
        if (!nrst)
            tovirq_r <= 1'b0;
        else
            tovirq_r <= tov_r & overflow_irq_enable; // RL18
    end

    // pin value, port value unless action nonzero
    always_ff @(posedge core_clk or negedge nrst)
    begin
        if (!nrst)
            pin_r <= 3'h0;
        else
        begin
            for (int i = 0; i < TOCC_NCH; i++)
                pin_r[i] <= (|compare_output_action[2*i +: 2])
                    ? latch_r[i] : port_value[i]; // RL15
        end
    end

    // pin enable, low while driving
    always_ff @(posedge core_clk or negedge nrst)
    begin
        if (!nrst)
            oen_r <= 3'h7;
        else
            oen_r <= ~output_pin_direction; // RL15
    end

    assign timer_count = cnt_r;
    assign compare_value = {ocr_r[2], ocr_r[1], ocr_r[0]}; // RL7
    assign compare_match_flag = flag_r;
    assign overflow_flag = tov_r;
    assign capture_flag = icf_r;
    assign compare_irq = irq_r;
    assign overflow_irq = tovirq_r;
    assign compare_output_latch = latch_r;
    assign pin_out = pin_r;
    assign pin_oe_n = oen_r;
endmodule : tocc_core

// ==== tb/tocc_chk.sv ====
`timescale 1ns/1ns
module tocc_chk
(
    // clock and reset
    input wire logic core_clk,
    input wire logic nrst,
    // controls
    input wire logic [3:0] waveform_mode_select,
    input wire logic [5:0] compare_output_action,
    input wire logic [2:0] compare_irq_enable,
    input wire logic overflow_irq_enable,
    input wire logic [7:0] cpu_wdata,
    input wire logic [2:0] compare_value_high_wr,
    input wire logic [2:0] compare_value_low_wr,
    input wire logic timer_count_high_wr,
    input wire logic timer_count_low_wr,
    input wire logic [2:0] compare_flag_clr,
    input wire logic [2:0] compare_irq_ack,
    input wire logic [2:0] port_value,
    input wire logic [2:0] output_pin_direction,
    // results
    input wire logic [15:0] timer_count,
    input wire logic [47:0] compare_value,
    input wire logic [2:0] compare_match_flag,
    input wire logic overflow_flag,
    input wire logic [2:0] compare_irq,
    input wire logic overflow_irq,
    input wire logic [2:0] compare_output_latch,
    input wire logic [2:0] pin_out,
    input wire logic [2:0] pin_oe_n
);
    logic [7:0] temp_r;
    logic [15:0] ld;
    logic [2:0] irq_x, nz, pin_x, dir_n;
    logic ovf_x, clr0, unbuf;
    assign ld = {temp_r, cpu_wdata};
    assign irq_x = compare_match_flag & compare_irq_enable;
    assign ovf_x = overflow_flag & overflow_irq_enable;
    assign nz = {|compare_output_action[5:4], |compare_output_action[3:2],
        |compare_output_action[1:0]};
    assign pin_x = (nz & compare_output_latch) | (~nz & port_value);
    assign dir_n = ~output_pin_direction;
    assign clr0 = compare_flag_clr[0] | compare_irq_ack[0];
    assign unbuf = waveform_mode_select inside {4'h0, 4'h4, 4'hC};
    // shared high byte holding copy
    always_ff @(posedge core_clk or negedge nrst)
        if (!nrst)
            temp_r <= 8'h00;
        else if (|{compare_value_high_wr, timer_count_high_wr})
            temp_r <= cpu_wdata;
    default clocking dc @(posedge core_clk);
    endclocking
    default disable iff (!nrst);
    sequence loaded;
        compare_value_low_wr[0] && unbuf;
    endsequence
    a_cmp_irq: assert property ($past(nrst) |->
        compare_irq == $past(irq_x)) else $error("compare irq wrong");
    a_ovf_irq: assert property ($past(nrst) |->
        overflow_irq == $past(ovf_x)) else $error("overflow irq wrong");
    a_pin_dir: assert property ($past(nrst) |->
        pin_oe_n == $past(dir_n)) else $error("pin enable wrong");
    a_pin_mux: assert property ($past(nrst) |->
        pin_out == $past(pin_x)) else $error("pin value wrong");
    a_flag_hold: assert property ($past(nrst) &&
        $fell(compare_match_flag[0]) |-> $past(clr0))
        else $error("flag fell uncleared");
    a_ovf_zero: assert property ($rose(overflow_flag) |->
        timer_count == 16'h0000) else $error("overflow off zero");
    a_cnt_load: assert property (timer_count_low_wr |=>
        timer_count == $past(ld)) else $error("count load wrong");
    a_cmp_load: assert property (loaded |=>
        compare_value[15:0] == $past(ld)) else $error("compare load wrong");
endmodule : tocc_chk

// ==== tb/tocc_ext.sv ====
`timescale 1ns/1ns
module tocc_ext
(
    // pin from the block
    input wire logic core_clk,
    input wire logic pin_out,
    input wire logic pin_oe_n,
    // observed level and edges
    output logic level,
    output int edges = 0
);
    logic prev = 1'b1;
    // released pin rests on its pull-up
    assign level = pin_oe_n ? 1'b1 : pin_out;
    always @(posedge core_clk)
    begin
        if (level != prev)
            edges++;
        prev = level;
    end
endmodule : tocc_ext

// ==== tb/tocc_tb_top.sv ====
`timescale 1ns/1ns
module timer16_output_compare_ctc_tb_top;
    logic core_clk, nrst, overflow_irq_enable, timer_count_high_wr, level;
    logic timer_count_low_wr, overflow_flag_clr, overflow_irq_ack;
    logic overflow_flag, capture_flag, overflow_irq;
    logic [3:0] waveform_mode_select;
    logic [2:0] clock_source_select, compare_irq_enable, compare_value_high_wr;
    logic [2:0] compare_value_low_wr, force_compare_strobe, compare_flag_clr;
    logic [2:0] compare_irq_ack, port_value, output_pin_direction, el;
    logic [2:0] compare_match_flag, compare_irq, compare_output_latch;
    logic [2:0] pin_out, pin_oe_n;
    logic [5:0] compare_output_action;
    logic [7:0] cpu_wdata;
    logic [15:0] capture_value, timer_count, v, mx;
    logic [15:0] exp_cv[3];
    logic [47:0] compare_value;
    int fails = 0, num_checks = 0, edges, cyc = 0, e0, i;
    int acts[5] = '{3, 1, 2, 1, 0};

    tocc_core dut (.*);
    tocc_ext ext (.core_clk, .pin_out(pin_out[0]), .pin_oe_n(pin_oe_n[0]),
        .level, .edges);

    always #50 core_clk = ~core_clk;
    always @(posedge core_clk)
    begin
        cyc++;
        if (cyc == 20000)
        begin
            fails++;
            print_verdict();
        end
    end

    task automatic print_verdict();
        $display("checks %0d fails %0d", num_checks, fails);
        if (fails == 0 && num_checks > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask : print_verdict

    task automatic step(int n = 1);
        repeat (n) @(posedge core_clk);
        #10;
    endtask : step

    task automatic chk(string nm, logic [15:0] seen, logic [15:0] exp);
        num_checks++;
        if (seen !== exp)
        begin
            fails++;
            $display("[ERR] %s exp %h seen %h", nm, exp, seen);
        end
    endtask : chk

    // high byte first, then low byte; k 3 is the counter
    task automatic wr16(int k, logic [15:0] d);
        cpu_wdata = d[15:8];
        {timer_count_high_wr, compare_value_high_wr} = 4'h1 << k;
        step();
        {timer_count_high_wr, compare_value_high_wr} = 4'h0;
        {timer_count_low_wr, compare_value_low_wr} = 4'h1 << k;
        cpu_wdata = d[7:0];
        step();
        {timer_count_low_wr, compare_value_low_wr} = 4'h0;
        step();
    endtask : wr16

    task automatic till_ovf();
        for (i = 0; i < 300 && !overflow_flag; i++)
            step();
    endtask : till_ovf

    initial
    begin
        core_clk = 1'b0;
        nrst = 1'b0;
        {waveform_mode_select, clock_source_select, compare_output_action} = 0;
        {compare_irq_enable, overflow_irq_enable, cpu_wdata} = 0;
        {compare_value_high_wr, compare_value_low_wr, force_compare_strobe} = 0;
        {timer_count_high_wr, timer_count_low_wr, capture_value} = 0;
        {compare_flag_clr, compare_irq_ack, overflow_flag_clr} = 0;
        {overflow_irq_ack, port_value, output_pin_direction} = 0;
        void'($urandom(32'h02B4EB95));
        step(2);
        nrst = 1'b1;
        chk("latch", compare_output_latch, 3'h0);
        chk("oe_n", pin_oe_n, 3'h7);
        for (i = 0; i < 4; i++)
        begin
            v = $urandom;
            wr16(i, v);
            if (i < 3)
                exp_cv[i] = v;
        end
        step(4);
        chk("count", timer_count, v);
        for (i = 0; i < 3; i++)
            chk("cmp", compare_value[i*16+:16], exp_cv[i]);
        $display("test load done");
        output_pin_direction = 3'h1;
        el = 3'h0;
        foreach (acts[k])
        begin
            compare_output_action = acts[k];
            port_value = $urandom;
            force_compare_strobe = 3'h1;
            step();
            force_compare_strobe = 3'h0;
            step(3);
            el[0] = acts[k] == 1 ? ~el[0] : acts[k] == 0 ? el[0] : acts[k] == 3;
            chk("latch", compare_output_latch, el);
            chk("flag", compare_match_flag, 3'h0);
            chk("pin", level, acts[k] ? el[0] : port_value[0]);
        end
        compare_output_action = 6'h01;
        waveform_mode_select = 4'h1;
        step();
        force_compare_strobe = 3'h1;
        step();
        force_compare_strobe = 3'h0;
        waveform_mode_select = 4'h4;
        step(3);
        chk("keep", compare_output_latch, el);
        output_pin_direction = 3'h0;
        step(3);
        chk("float", pin_oe_n[0], 1'b1);
        $display("test force done");
        waveform_mode_select = 4'h0;
        compare_output_action = 6'h00;
        wr16(1, 16'h0030);
        wr16(3, 16'hFFF0);
        compare_irq_enable = 3'h2;
        overflow_irq_enable = 1'b1;
        clock_source_select = 3'h1;
        till_ovf();
        chk("wrap", {overflow_flag, timer_count[15:4]}, 13'h1000);
        for (i = 0; i < 300 && !compare_match_flag[1]; i++)
            step();
        chk("match", timer_count[15:4], 12'h003);
        step(2);
        chk("irq", {compare_irq, overflow_irq}, 4'h5);
        compare_irq_ack = 3'h2;
        overflow_flag_clr = 1'b1;
        step();
        compare_irq_ack = 3'h0;
        overflow_flag_clr = 1'b0;
        step(2);
        chk("clr", {compare_match_flag[1], overflow_flag}, 2'h0);
        $display("test normal done");
        clock_source_select = 3'h0;
        waveform_mode_select = 4'h4;
        compare_output_action = 6'h01;
        output_pin_direction = 3'h1;
        wr16(0, 16'h0005);
        wr16(3, 16'h0000);
        compare_flag_clr = 3'h1;
        step();
        compare_flag_clr = 3'h0;
        e0 = edges;
        mx = 16'h0000;
        clock_source_select = 3'h1;
        for (i = 0; i < 100; i++)
        begin
            step();
            if (timer_count > mx)
                mx = timer_count;
        end
        chk("top", mx, 16'h0005);
        chk("flag", compare_match_flag[0], 1'b1);
        chk("tgl", edges - e0 > 4, 1'b1);
        wr16(3, 16'hFFF0);
        till_ovf();
        chk("miss", overflow_flag, 1'b1);
        $display("test clear done");
        clock_source_select = 3'h0;
        waveform_mode_select = 4'h0;
        wr16(2, 16'h0040);
        compare_flag_clr = 3'h7;
        step();
        compare_flag_clr = 3'h0;
        wr16(3, 16'h0040);
        step(3);
        clock_source_select = 3'h1;
        step(20);
        chk("block", compare_match_flag[2], 1'b0);
        $display("test block done");
        clock_source_select = 3'h0;
        waveform_mode_select = 4'hC;
        capture_value = 16'h0003;
        wr16(3, 16'h0000);
        mx = 16'h0000;
        clock_source_select = 3'h1;
        for (i = 0; i < 40; i++)
        begin
            step();
            if (timer_count > mx)
                mx = timer_count;
        end
        chk("cap top", mx, 16'h0003);
        chk("cap flag", capture_flag, 1'b1);
        $display("test capture done");
        clock_source_select = 3'h0;
        step();
        waveform_mode_select = 4'h5;
        wr16(1, 16'h1234);
        chk("held", compare_value[31:16], 16'h0030);
        wr16(3, 16'h0000);
        clock_source_select = 3'h1;
        step(3);
        chk("reload", compare_value[31:16], 16'h1234);
        $display("test buffer done");
        print_verdict();
    end
endmodule : timer16_output_compare_ctc_tb_top

bind tocc_core tocc_chk u_chk (.*);
